//--- rtl/feature_control_command_handler.sv
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1 - action code 0004h selects feature control
// R2 - function 0001h sets addressed feature state
// R3 - function 0002h reports state, leaves it
// R4 - function 0003h reports feature option flags
// R5 - host fills words 2-4, zeros rest
// R6 - option bit 0 set: state kept persistently
// R7 - bit 0 clear: volatile, reset restores stored
// R8 - success returns error 00h, status 50h
// R9 - state low byte count, high number
// R10 - flags low byte count, high number
// R11 - write cache: defer, force on, off
// R12 - deferring: follow latest host set-feature
// R13 - forced state overrides host set-feature
// R14 - set-feature while forced completes, no effect
// R15 - identify word 85 bit 5 true cache
// R16 - reordering feature: 0001h on, 0002h off
// R17 - both features default to state 0001h
// R18 - unsupported codes abort, states unchanged
module feature_control_command_handler (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire fc_pkg::ahb_req_t ahb_i,
  output var  fc_pkg::ahb_rsp_t ahb_o,
  input  wire fc_pkg::nv_in_t   nv_i,
  output var  fc_pkg::nv_out_t  nv_o,
  output logic                  wcache_on,
  output logic                  reorder_on,
  output logic                  id_w85_wc
);
  fc_pkg::fc_state_t s_q;
  fc_pkg::fc_state_t s_d;

  logic [15:0] wc_state;
  logic [15:0] ro_state;
  logic        wc_load;
  logic        ro_load;
  logic        wc_set;
  logic        ro_set;
  logic        addr_ph;
  logic [7:0]  addr_ofs;
  logic [31:0] rd_mux;
  logic [31:0] status_w;
  logic [31:0] id85_w;
  logic        is_wc;
  logic        act_ok;
  logic        fn_ok;
  logic        ft_ok;
  logic        st_ok;
  logic        req_ok;
  logic        is_set;
  logic [15:0] cur_state;
  logic        cur_opt;
  logic        go_wr;
  logic        sf_wr;

  feature_slot #(
    .DEFAULT (fc_pkg::WC_DEFAULT)
  ) u_wc_slot (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (wc_load),
    .load_ok  (nv_i.wc_valid),
    .load_val (nv_i.wc_state),
    .set      (wc_set),
    .set_val  (s_q.w_state),
    .state    (wc_state)
  );

  feature_slot #(
    .DEFAULT (fc_pkg::RO_DEFAULT)
  ) u_ro_slot (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (ro_load),
    .load_ok  (nv_i.ro_valid),
    .load_val (nv_i.ro_state),
    .set      (ro_set),
    .set_val  (s_q.w_state),
    .state    (ro_state)
  );

  assign addr_ph  = ahb_i.hsel & ahb_i.htrans[fc_pkg::HTRANS_ACT_BIT] & ahb_i.hready;
  assign addr_ofs = ahb_i.haddr[fc_pkg::OFS_W-1:0];
  assign go_wr    = s_q.a_on & s_q.a_wr & (s_q.a_ofs == fc_pkg::OFS_CTRL)
                  & ahb_i.hwdata[fc_pkg::CTRL_GO_BIT] & (s_q.fsm == fc_pkg::FSM_IDLE);
  assign sf_wr    = s_q.a_on & s_q.a_wr & (s_q.a_ofs == fc_pkg::OFS_SETFEAT);

  // request decode over the latched parameter words
  assign is_wc  = s_q.w_feat == fc_pkg::FEAT_WCACHE;
  assign act_ok = s_q.w_action == fc_pkg::ACT_FEATURE_CTRL; // R1
  assign fn_ok  = s_q.w_func inside {fc_pkg::FN_SET_STATE, fc_pkg::FN_GET_STATE, fc_pkg::FN_GET_FLAGS};
  assign ft_ok  = s_q.w_feat inside {fc_pkg::FEAT_WCACHE, fc_pkg::FEAT_REORDER};
  assign st_ok  = is_wc ? (s_q.w_state inside {fc_pkg::WC_DEFER, fc_pkg::WC_FORCE_ON, fc_pkg::WC_FORCE_OFF})
                        : (s_q.w_state inside {fc_pkg::RO_ENABLE, fc_pkg::RO_DISABLE}); // R11 R16
  assign is_set = s_q.w_func == fc_pkg::FN_SET_STATE;
  assign req_ok = act_ok & fn_ok & ft_ok & (st_ok | ~is_set); // R18

  assign cur_state = is_wc ? wc_state : ro_state;
  assign cur_opt   = is_wc ? s_q.opt_wc : s_q.opt_ro;

  always_comb begin
    status_w = '0;
    status_w[fc_pkg::STS_BUSY]  = s_q.fsm != fc_pkg::FSM_IDLE;
    status_w[fc_pkg::STS_DONE]  = s_q.done;
    status_w[fc_pkg::STS_ABORT] = s_q.abort;
    status_w[fc_pkg::STS_WC]    = s_q.wc_on;
    status_w[fc_pkg::STS_RO]    = s_q.ro_on;
    id85_w = '0;
    id85_w[fc_pkg::ID85_WC_BIT] = s_q.wc_on; // R15
  end

  always_comb begin
    case (addr_ofs)
      fc_pkg::OFS_ACTION:  rd_mux = {16'h0000, s_q.w_action};
      fc_pkg::OFS_FUNC:    rd_mux = {16'h0000, s_q.w_func};
      fc_pkg::OFS_FEAT:    rd_mux = {16'h0000, s_q.w_feat};
      fc_pkg::OFS_STATE:   rd_mux = {16'h0000, s_q.w_state};
      fc_pkg::OFS_OPTS:    rd_mux = {16'h0000, s_q.w_opts};
      fc_pkg::OFS_SETFEAT: rd_mux = {31'h0, s_q.setfeat_wc};
      fc_pkg::OFS_RESULT:  rd_mux = s_q.res;
      fc_pkg::OFS_STATUS:  rd_mux = status_w;
      fc_pkg::OFS_ID85:    rd_mux = id85_w;
      fc_pkg::OFS_CUR:     rd_mux = {ro_state, wc_state};
      default:             rd_mux = '0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.nv.wr = 1'b0;
    wc_load = 1'b0;
    ro_load = 1'b0;
    wc_set = 1'b0;
    ro_set = 1'b0;

    // bus: latch address phase, reads answered from a flop
    if (ahb_i.hready) begin
      s_d.a_on  = addr_ph;
      s_d.a_wr  = ahb_i.hwrite;
      s_d.a_ofs = addr_ofs;
    end
    if (addr_ph && !ahb_i.hwrite) begin
      s_d.rdata = rd_mux;
    end

    // bus: write data phase
    if (s_q.a_on && s_q.a_wr) begin
      case (s_q.a_ofs)
        fc_pkg::OFS_ACTION: s_d.w_action = ahb_i.hwdata[fc_pkg::WORD_W-1:0];
        fc_pkg::OFS_FUNC:   s_d.w_func   = ahb_i.hwdata[fc_pkg::WORD_W-1:0];
        fc_pkg::OFS_FEAT:   s_d.w_feat   = ahb_i.hwdata[fc_pkg::WORD_W-1:0];
        fc_pkg::OFS_STATE:  s_d.w_state  = ahb_i.hwdata[fc_pkg::WORD_W-1:0];
        fc_pkg::OFS_OPTS:   s_d.w_opts   = ahb_i.hwdata[fc_pkg::WORD_W-1:0];
        default: ;
      endcase
    end

    // host set-feature always accepted; forcing decides its effect
    if (sf_wr) begin
      s_d.setfeat_wc = ahb_i.hwdata[fc_pkg::SETFEAT_WC_BIT]; // R14
    end

    case (s_q.fsm)
      fc_pkg::FSM_LOAD: begin
        wc_load = 1'b1; // R17
        ro_load = 1'b1; // R17
        s_d.opt_wc = nv_i.wc_valid;
        s_d.opt_ro = nv_i.ro_valid;
        s_d.fsm = fc_pkg::FSM_IDLE;
      end
      fc_pkg::FSM_IDLE: begin
        if (go_wr) begin
          s_d.fsm = fc_pkg::FSM_EXEC;
          s_d.done = 1'b0;
          s_d.abort = 1'b0;
        end
      end
      fc_pkg::FSM_EXEC: begin
        s_d.fsm = fc_pkg::FSM_IDLE;
        s_d.done = 1'b1;
        s_d.res.err = fc_pkg::TF_ERR_OK; // R8
        s_d.res.stat = fc_pkg::TF_STAT_OK; // R8
        s_d.res.sc = fc_pkg::TF_RSVD;
        s_d.res.sn = fc_pkg::TF_RSVD;
        if (!req_ok) begin
          s_d.abort = 1'b1;
          s_d.res.err = fc_pkg::TF_ERR_ABRT; // R18
          s_d.res.stat = fc_pkg::TF_STAT_ERR; // R18
        end else begin
          case (s_q.w_func)
            fc_pkg::FN_SET_STATE: begin
              wc_set = is_wc; // R2
              ro_set = ~is_wc; // R2
              if (is_wc) begin
                s_d.opt_wc = s_q.w_opts[fc_pkg::OPT_PERSIST_BIT];
              end else begin
                s_d.opt_ro = s_q.w_opts[fc_pkg::OPT_PERSIST_BIT];
              end
              // only a persistent request reaches the stored copy
              s_d.nv.wr = s_q.w_opts[fc_pkg::OPT_PERSIST_BIT]; // R6 R7
              s_d.nv.feat = s_q.w_feat;
              s_d.nv.state = s_q.w_state;
            end
            fc_pkg::FN_GET_STATE: begin
              {s_d.res.sn, s_d.res.sc} = cur_state; // R3 R9
            end
            fc_pkg::FN_GET_FLAGS: begin
              {s_d.res.sn, s_d.res.sc} = {15'h0000, cur_opt}; // R4 R10
            end
            default: ;
          endcase
        end
      end
      default: begin
        s_d.fsm = fc_pkg::FSM_IDLE;
      end
    endcase

    // effective cache state
    case (wc_state)
      fc_pkg::WC_DEFER:    s_d.wc_on = s_q.setfeat_wc; // R12
      fc_pkg::WC_FORCE_ON: s_d.wc_on = 1'b1; // R13
      default:             s_d.wc_on = 1'b0; // R13
    endcase
    s_d.ro_on = ro_state == fc_pkg::RO_ENABLE; // R16
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= fc_pkg::FC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp     = fc_pkg::HRESP_OKAY;
  assign ahb_o.hrdata    = s_q.rdata;
  assign nv_o            = s_q.nv;
  assign wcache_on       = s_q.wc_on;
  assign reorder_on      = s_q.ro_on;
  assign id_w85_wc       = id85_w[fc_pkg::ID85_WC_BIT]; // R15

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic ex;
  assign ex = s_q.fsm == fc_pkg::FSM_EXEC;

  sequence exec_then_done_s;
    (s_q.fsm == fc_pkg::FSM_EXEC) ##1 (s_q.done && s_q.fsm == fc_pkg::FSM_IDLE);
  endsequence

  sequence set_req_s;
    ex && req_ok && is_set;
  endsequence

  go_exec_done_a: assert property (go_wr |=> exec_then_done_s) // R1
    else $error("go write did not run one command");

  bad_action_a: assert property (ex && !act_ok |=> s_q.abort && s_q.res.err == fc_pkg::TF_ERR_ABRT) // R1
    else $error("wrong action code not aborted");

  abort_keep_a: assert property (ex && !req_ok |=> // R18
      s_q.res.stat == fc_pkg::TF_STAT_ERR && $stable(wc_state) && $stable(ro_state))
    else $error("aborted request changed a state");

  set_state_a: assert property (set_req_s |=> cur_state == $past(s_q.w_state)) // R2
    else $error("set request did not store state");

  get_keep_a: assert property (ex && req_ok && s_q.w_func == fc_pkg::FN_GET_STATE |=> // R3
      $stable(wc_state) && $stable(ro_state))
    else $error("get request changed a state");

  get_bytes_a: assert property (ex && req_ok && s_q.w_func == fc_pkg::FN_GET_STATE |=> // R9
      {s_q.res.sn, s_q.res.sc} == $past(cur_state))
    else $error("returned state bytes wrong");

  flag_bytes_a: assert property (ex && req_ok && s_q.w_func == fc_pkg::FN_GET_FLAGS |=> // R10
      {s_q.res.sn, s_q.res.sc} == {15'h0000, $past(cur_opt)})
    else $error("returned flag bytes wrong");

  persist_wr_a: assert property (set_req_s and s_q.w_opts[fc_pkg::OPT_PERSIST_BIT] |=> // R6
      s_q.nv.wr && s_q.nv.state == $past(s_q.w_state) ##1 !s_q.nv.wr)
    else $error("persistent store not written once");

  volatile_set_a: assert property (set_req_s and !s_q.w_opts[fc_pkg::OPT_PERSIST_BIT] |=> !s_q.nv.wr) // R7
    else $error("volatile set wrote the stored copy");

  ok_result_a: assert property (ex && req_ok |=> // R8
      s_q.res.err == fc_pkg::TF_ERR_OK && s_q.res.stat == fc_pkg::TF_STAT_OK && !s_q.abort)
    else $error("successful request result wrong");

  defer_follow_a: assert property (wc_state == fc_pkg::WC_DEFER && sf_wr |=> // R12
      ##1 (wcache_on == $past(ahb_i.hwdata[fc_pkg::SETFEAT_WC_BIT], 2)))
    else $error("deferring cache ignored set-feature");

  forced_hold_a: assert property (wc_state == fc_pkg::WC_FORCE_OFF && $stable(wc_state) [*2] |-> // R13
      !wcache_on)
    else $error("forced off cache is enabled");

  forced_sf_a: assert property (wc_state == fc_pkg::WC_FORCE_ON && sf_wr |=> // R14
      wcache_on && !s_q.abort ##1 wcache_on)
    else $error("set-feature changed forced cache");

  // the identify bit follows the state and set-feature one edge later
  id85_true_a: assert property (id_w85_wc == wcache_on && id_w85_wc == s_q.wc_on && // R15
      (s_q.fsm == fc_pkg::FSM_LOAD ||
       id_w85_wc == ($past(wc_state) == fc_pkg::WC_FORCE_ON ||
                     ($past(wc_state) == fc_pkg::WC_DEFER && $past(s_q.setfeat_wc)))))
    else $error("identify bit differs from cache state");

  load_default_a: assert property (s_q.fsm == fc_pkg::FSM_LOAD && !nv_i.wc_valid |=> // R17
      wc_state == fc_pkg::WC_DEFAULT && s_q.fsm == fc_pkg::FSM_IDLE)
    else $error("cache state not default after reset");

  forced_on_a: assert property (wc_state == fc_pkg::WC_FORCE_ON && $stable(wc_state) [*2] |-> // R13
      wcache_on)
    else $error("forced on cache is disabled");

  reorder_map_a: assert property (s_q.fsm != fc_pkg::FSM_LOAD |-> // R16
      reorder_on == ($past(ro_state) == fc_pkg::RO_ENABLE))
    else $error("reordering differs from its state");

  set_wc_only_a: assert property (set_req_s and is_wc |=> // R2
      $stable(ro_state))
    else $error("cache set changed reordering state");

  set_ro_only_a: assert property (set_req_s and !is_wc |=> // R2
      $stable(wc_state))
    else $error("reordering set changed cache state");

  flags_track_a: assert property (set_req_s |=> // R4
      cur_opt == $past(s_q.w_opts[fc_pkg::OPT_PERSIST_BIT]))
    else $error("option flag not taken from set");

  persist_feat_a: assert property (set_req_s and s_q.w_opts[fc_pkg::OPT_PERSIST_BIT] |=> // R6
      nv_o.feat == $past(s_q.w_feat))
    else $error("stored copy written for wrong feature");

  idle_no_store_a: assert property (!ex |=> // R6
      !s_q.nv.wr)
    else $error("stored copy written outside a command");

  sf_accept_a: assert property (sf_wr |=> // R14
      s_q.setfeat_wc == $past(ahb_i.hwdata[fc_pkg::SETFEAT_WC_BIT]))
    else $error("set-feature request not accepted");

  load_stored_a: assert property (s_q.fsm == fc_pkg::FSM_LOAD && nv_i.wc_valid |=> // R7
      wc_state == $past(nv_i.wc_state) && s_q.opt_wc)
    else $error("stored cache state not restored");
endmodule
`default_nettype wire

//--- inc/fc_pkg.sv
package fc_pkg;
  localparam int WORD_W = 16;
  localparam int OFS_W  = 8;

  localparam logic [15:0] ACT_FEATURE_CTRL = 16'h0004;
  localparam logic [15:0] FN_SET_STATE     = 16'h0001;
  localparam logic [15:0] FN_GET_STATE     = 16'h0002;
  localparam logic [15:0] FN_GET_FLAGS     = 16'h0003;
  localparam logic [15:0] FEAT_WCACHE      = 16'h0001;
  localparam logic [15:0] FEAT_REORDER     = 16'h0002;
  localparam logic [15:0] WC_DEFER         = 16'h0001;
  localparam logic [15:0] WC_FORCE_ON      = 16'h0002;
  localparam logic [15:0] WC_FORCE_OFF     = 16'h0003;
  localparam logic [15:0] RO_ENABLE        = 16'h0001;
  localparam logic [15:0] RO_DISABLE       = 16'h0002;
  localparam logic [15:0] WC_DEFAULT       = WC_DEFER;
  localparam logic [15:0] RO_DEFAULT       = RO_ENABLE;
  localparam int          OPT_PERSIST_BIT  = 0;

  localparam logic [7:0] TF_ERR_OK   = 8'h00;
  localparam logic [7:0] TF_STAT_OK  = 8'h50;
  localparam logic [7:0] TF_ERR_ABRT = 8'h04;
  localparam logic [7:0] TF_STAT_ERR = 8'h51;
  localparam logic [7:0] TF_RSVD     = 8'h00;
  localparam int         ID85_WC_BIT = 5;

  localparam logic [7:0] OFS_ACTION  = 8'h00;
  localparam logic [7:0] OFS_FUNC    = 8'h04;
  localparam logic [7:0] OFS_FEAT    = 8'h08;
  localparam logic [7:0] OFS_STATE   = 8'h0c;
  localparam logic [7:0] OFS_OPTS    = 8'h10;
  localparam logic [7:0] OFS_CTRL    = 8'h14;
  localparam logic [7:0] OFS_SETFEAT = 8'h18;
  localparam logic [7:0] OFS_RESULT  = 8'h1c;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_ID85    = 8'h24;
  localparam logic [7:0] OFS_CUR     = 8'h28;

  localparam int CTRL_GO_BIT    = 0;
  localparam int SETFEAT_WC_BIT = 0;
  localparam int STS_BUSY       = 0;
  localparam int STS_DONE       = 1;
  localparam int STS_ABORT      = 2;
  localparam int STS_WC         = 3;
  localparam int STS_RO         = 4;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic HRESP_OKAY   = 1'b0;

  typedef enum logic [2:0] {
    FSM_LOAD = 3'b001,
    FSM_IDLE = 3'b010,
    FSM_EXEC = 3'b100
  } fsm_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  typedef struct packed {
    logic        wc_valid;
    logic [15:0] wc_state;
    logic        ro_valid;
    logic [15:0] ro_state;
  } nv_in_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] feat;
    logic [15:0] state;
  } nv_out_t;

  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] sn;
    logic [7:0] sc;
    logic [7:0] err;
  } result_t;

  typedef struct packed {
    logic [15:0] state;
  } slot_t;

  typedef struct packed {
    fsm_t        fsm;
    logic        a_on;
    logic        a_wr;
    logic [7:0]  a_ofs;
    logic [31:0] rdata;
    logic [15:0] w_action;
    logic [15:0] w_func;
    logic [15:0] w_feat;
    logic [15:0] w_state;
    logic [15:0] w_opts;
    logic        setfeat_wc;
    result_t     res;
    logic        done;
    logic        abort;
    logic        opt_wc;
    logic        opt_ro;
    logic        wc_on;
    logic        ro_on;
    nv_out_t     nv;
  } fc_state_t;

  localparam fc_state_t FC_RST = '{fsm: FSM_LOAD, default: '0};
endpackage

//--- rtl/feature_slot.sv
`timescale 1ns/10ps
`default_nettype none
module feature_slot #(
  parameter logic [15:0] DEFAULT = 16'h0001
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        load,
  input  wire logic        load_ok,
  input  wire logic [15:0] load_val,
  input  wire logic        set,
  input  wire logic [15:0] set_val,
  output logic      [15:0] state
);
  fc_pkg::slot_t s_q;
  fc_pkg::slot_t s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      // stored value after power up, default when none is kept
      s_d.state = load_ok ? load_val : DEFAULT; // R7
    end else if (set) begin
      s_d.state = set_val;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.state <= DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  assign state = s_q.state;
endmodule
`default_nettype wire

//--- testbench/nv_store.sv
`timescale 1ns/10ps
`default_nettype none
module nv_store (
  input  wire fc_pkg::nv_out_t nv_o,
  input  wire logic            clk,
  output var  fc_pkg::nv_in_t  nv_i
);
  // the persistent copy ignores arst_n: it models storage that outlives power cycles
  fc_pkg::nv_in_t mem_q = '0;

  always @(posedge clk) begin
    if (nv_o.wr && nv_o.feat == fc_pkg::FEAT_WCACHE) begin
      mem_q.wc_valid <= 1'b1;
      mem_q.wc_state <= nv_o.state;
    end
    if (nv_o.wr && nv_o.feat == fc_pkg::FEAT_REORDER) begin
      mem_q.ro_valid <= 1'b1;
      mem_q.ro_state <= nv_o.state;
    end
  end

  assign nv_i = mem_q;
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic             clk        = 1'b0;
  logic             arst_n     = 1'b0;
  logic             hsel       = 1'b0;
  logic [31:0]      haddr      = 32'h0;
  logic [1:0]       htrans     = 2'h0;
  logic             hwrite     = 1'b0;
  logic [31:0]      hwdata     = 32'h0;
  logic [31:0]      rd;
  int               fails      = 0;
  int               n_compared = 0;
  logic             wc_on;
  logic             ro_on;
  logic             id85;
  fc_pkg::ahb_req_t ahb_i;
  fc_pkg::ahb_rsp_t ahb_o;
  fc_pkg::nv_in_t   nv_i;
  fc_pkg::nv_out_t  nv_o;
  // action, function, feature, state of requests that must be refused
  logic [63:0]      bad [7]    = '{64'h0003_0002_0001_0000, 64'h0004_0000_0001_0001,
                                   64'h0004_0004_0001_0001, 64'h0004_0002_0003_0000,
                                   64'h0004_0001_0001_0004, 64'h0004_0001_0001_0000,
                                   64'h0004_0001_0002_0003};

  assign ahb_i = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
                   hwdata: hwdata, hready: ahb_o.hreadyout};

  always #50 clk = ~clk;

  feature_control_command_handler u_dut (
    .clk        (clk),
    .arst_n     (arst_n),
    .ahb_i      (ahb_i),
    .ahb_o      (ahb_o),
    .nv_i       (nv_i),
    .nv_o       (nv_o),
    .wcache_on  (wc_on),
    .reorder_on (ro_on),
    .id_w85_wc  (id85)
  );

  nv_store u_nv (
    .nv_o (nv_o),
    .clk  (clk),
    .nv_i (nv_i)
  );

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      fails++;
    end
  endtask

  // one single AHB transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
    rd = ahb_o.hrdata;
  endtask

  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(s, e, rd);
    chk("hresp", {31'h0, fc_pkg::HRESP_OKAY}, {31'h0, ahb_o.hresp});
  endtask

  // full command; leaves the result word in rd
  task automatic cmd(input logic [15:0] ac, fn, ft, st, op);
    int i;
    xfer(1'b1, fc_pkg::OFS_ACTION, {16'h0, ac});
    xfer(1'b1, fc_pkg::OFS_FUNC, {16'h0, fn});
    xfer(1'b1, fc_pkg::OFS_FEAT, {16'h0, ft});
    xfer(1'b1, fc_pkg::OFS_STATE, {16'h0, st});
    xfer(1'b1, fc_pkg::OFS_OPTS, {16'h0, op});
    xfer(1'b1, fc_pkg::OFS_CTRL, 32'h1);
    i = 0;
    do begin
      xfer(1'b0, fc_pkg::OFS_STATUS, 32'h0);
      i++;
    end while (rd[fc_pkg::STS_DONE] !== 1'b1 && i < 10);
    chk("done", 32'h1, {31'h0, rd[fc_pkg::STS_DONE]});
    xfer(1'b0, fc_pkg::OFS_RESULT, 32'h0);
  endtask

  task automatic sfeat(input logic v);
    xfer(1'b1, fc_pkg::OFS_SETFEAT, {31'h0, v});
  endtask

  task automatic ports(input logic w, input logic r);
    idle(2);
    chk("wcache_on", {31'h0, w}, {31'h0, wc_on});
    chk("id_w85_wc", {31'h0, w}, {31'h0, id85});
    chk("reorder_on", {31'h0, r}, {31'h0, ro_on});
  endtask

  task automatic rst;
    arst_n <= 1'b0;
    idle(8);
    arst_n <= 1'b1;
    idle(2);
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin
    rst();
    rchk("cur", fc_pkg::OFS_CUR, 32'h0001_0001);
    rchk("status", fc_pkg::OFS_STATUS, 32'h10);
    ports(1'b0, 1'b1);
    rchk("unmapped", 8'h30, 32'h0);
    rchk("ctrl", fc_pkg::OFS_CTRL, 32'h0);
    tend("defaults");
    sfeat(1'b1);
    ports(1'b1, 1'b1);
    rchk("id85", fc_pkg::OFS_ID85, 32'h20);
    sfeat(1'b0);
    ports(1'b0, 1'b1);
    tend("defer");
    cmd(16'h0004, 16'h0001, 16'h0001, 16'h0002, 16'h0000);
    chk("result", 32'h5000_0000, rd);
    ports(1'b1, 1'b1);
    sfeat(1'b1);
    sfeat(1'b0);
    ports(1'b1, 1'b1);
    rchk("status", fc_pkg::OFS_STATUS, 32'h1a);
    cmd(16'h0004, 16'h0001, 16'h0001, 16'h0003, 16'h0000);
    ports(1'b0, 1'b1);
    sfeat(1'b1);
    ports(1'b0, 1'b1);
    cmd(16'h0004, 16'h0001, 16'h0001, 16'h0001, 16'h0000);
    ports(1'b1, 1'b1);
    cmd(16'h0004, 16'h0002, 16'h0001, 16'h0000, 16'h0000);
    chk("get wc", 32'h5000_0100, rd);
    rchk("cur", fc_pkg::OFS_CUR, 32'h0001_0001);
    tend("write cache");
    cmd(16'h0004, 16'h0001, 16'h0002, 16'h0002, 16'h0000);
    ports(1'b1, 1'b0);
    cmd(16'h0004, 16'h0002, 16'h0002, 16'h0000, 16'h0000);
    chk("get ro", 32'h5000_0200, rd);
    cmd(16'h0004, 16'h0001, 16'h0002, 16'h0001, 16'h0000);
    ports(1'b1, 1'b1);
    tend("reorder");
    cmd(16'h0004, 16'h0001, 16'h0001, 16'h0003, 16'h0001);
    cmd(16'h0004, 16'h0001, 16'h0002, 16'h0002, 16'h0000);
    cmd(16'h0004, 16'h0003, 16'h0001, 16'h0000, 16'h0000);
    chk("flags wc", 32'h5000_0100, rd);
    cmd(16'h0004, 16'h0003, 16'h0002, 16'h0000, 16'h0000);
    chk("flags ro", 32'h5000_0000, rd);
    rst();
    rchk("cur", fc_pkg::OFS_CUR, 32'h0001_0003);
    ports(1'b0, 1'b1);
    cmd(16'h0004, 16'h0003, 16'h0001, 16'h0000, 16'h0000);
    chk("flags wc", 32'h5000_0100, rd);
    tend("persistence");
    for (int i = 0; i < 7; i++) begin
      cmd(bad[i][63:48], bad[i][47:32], bad[i][31:16], bad[i][15:0], 16'h0000);
      chk("abort result", 32'h5100_0004, rd);
      rchk("abort status", fc_pkg::OFS_STATUS, 32'h16);
      rchk("abort cur", fc_pkg::OFS_CUR, 32'h0001_0003);
    end
    tend("aborts");
    complete_run();
  end
endmodule
`default_nettype wire
